// ### ias_interrupt_ack_standby.sv
// maskable interrupt acknowledge and standby control for a small cpu core
// assumes the cpu sequencer flags the last clock of each instruction and
// performs the stack pushes and pc load on the strobes given here
`timescale 1ns/1ns
module ias_interrupt_ack_standby #(
   parameter int SETTLE_CYC_0 = ias_pkg::SETTLE_CYC_0,
   parameter int SETTLE_CYC_1 = ias_pkg::SETTLE_CYC_1,
   parameter int SETTLE_CYC_2 = ias_pkg::SETTLE_CYC_2,
   parameter int SETTLE_CYC_3 = ias_pkg::SETTLE_CYC_3
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic [13:0] srcEvent,
   input  wire logic [15:0] regAddr,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   input  wire logic        instrEnd,
   input  wire logic        ieWrEn,
   input  wire logic        ieWrVal,
   output logic             ieFlag,
   output logic             ackStart,
   output logic             pushPswStb,
   output logic             pushPcStb,
   output logic             loadPcStb,
   output logic      [15:0] vectorAddr,
   input  wire logic        haltReq,
   input  wire logic        stopReq,
   input  wire logic        sysClkResonator,
   input  wire logic        oscRunning,
   input  wire logic        lowOscTick,
   input  wire logic        optLowOscStoppable,
   output logic             cpuClkStop,
   output logic             sysOscStop,
   output logic             lowOscRun,
   output logic             cpuStall,
   output logic             standbyWake
);

   // -----------------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------------
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      return a == b;
   endfunction : hit

   function automatic logic [17:0] settleLen(input logic [1:0] code);
      unique case (code)
         2'h0:    settleLen = 18'(SETTLE_CYC_0);
         2'h1:    settleLen = 18'(SETTLE_CYC_1);
         2'h2:    settleLen = 18'(SETTLE_CYC_2);
         2'h3:    settleLen = 18'(SETTLE_CYC_3);
      endcase
   endfunction : settleLen

   // -----------------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------------
   logic [13:0]              reqFlags_r;
   logic [13:0]              reqFlags_nxt;
   logic [13:0]              maskFlags_r;
   logic [1:0]               settleSel_r;
   logic                     lsStop_r;
   logic                     ie_r;
   logic [13:0]              ackable;
   logic [13:0]              ackableDly_r;
   logic                     holdOff_r;
   logic                     flagAccess;
   logic                     pickValid;
   logic [3:0]               pickIdx;
   logic [13:0]              pickOneHot;
   logic                     grant;
   logic [3:0]               grantIdx_r;
   ias_pkg::ias_ack_state_t  ackState_r;
   ias_pkg::ias_sby_state_t  sbyState_r;
   logic                     wake;
   logic                     lowOscRun_r;
   logic [3:0]               lsTickCnt_r;
   logic                     settleStart;
   logic                     settleBusy;
   logic                     settleDone;

   // -----------------------------------------------------------------------
   // request and mask flags
   // -----------------------------------------------------------------------
   assign ackable = reqFlags_r & ~maskFlags_r;
   assign wake    = |ackable;
   assign flagAccess = (regWrEn || regRdEn) &&
                       (hit(regAddr, ias_pkg::ADDR_REQ_LO) ||
                        hit(regAddr, ias_pkg::ADDR_REQ_HI) ||
                        hit(regAddr, ias_pkg::ADDR_MASK_LO) ||
                        hit(regAddr, ias_pkg::ADDR_MASK_HI));

   always_comb begin
      reqFlags_nxt = reqFlags_r;
      if (regWrEn && hit(regAddr, ias_pkg::ADDR_REQ_LO)) begin
         reqFlags_nxt[7:0] = regWrData;
      end
      if (regWrEn && hit(regAddr, ias_pkg::ADDR_REQ_HI)) begin
         reqFlags_nxt[13:8] = regWrData[5:0];
      end
      if (grant) begin
         reqFlags_nxt = reqFlags_nxt & ~pickOneHot;
      end
      // a new event wins over any clear in the same cycle
      reqFlags_nxt = reqFlags_nxt | srcEvent;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         reqFlags_r <= ias_pkg::REQ_RESET;
      end else begin
         reqFlags_r <= reqFlags_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         maskFlags_r <= ias_pkg::MASK_RESET;
      end else if (regWrEn && hit(regAddr, ias_pkg::ADDR_MASK_LO)) begin
         maskFlags_r[7:0] <= regWrData;
      end else if (regWrEn && hit(regAddr, ias_pkg::ADDR_MASK_HI)) begin
         maskFlags_r[13:8] <= regWrData[5:0];
      end
   end

   // -----------------------------------------------------------------------
   // standby configuration registers
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         settleSel_r <= ias_pkg::SETTLE_RESET;
         lsStop_r    <= ias_pkg::LS_STOP_RST;
      end else if (regWrEn && hit(regAddr, ias_pkg::ADDR_SETTLE)) begin
         settleSel_r <= regWrData[ias_pkg::SETTLE_LSB +: 2];
      end else if (regWrEn && hit(regAddr, ias_pkg::ADDR_LS_MODE)) begin
         lsStop_r    <= regWrData[ias_pkg::LS_STOP_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         regRdData <= 8'h00;
      end else if (regRdEn) begin
         if (hit(regAddr, ias_pkg::ADDR_REQ_LO)) begin
            regRdData <= reqFlags_r[7:0];
         end else if (hit(regAddr, ias_pkg::ADDR_REQ_HI)) begin
            regRdData <= {2'h0, reqFlags_r[13:8]};
         end else if (hit(regAddr, ias_pkg::ADDR_MASK_LO)) begin
            regRdData <= maskFlags_r[7:0];
         end else if (hit(regAddr, ias_pkg::ADDR_MASK_HI)) begin
            regRdData <= {2'h3, maskFlags_r[13:8]};
         end else if (hit(regAddr, ias_pkg::ADDR_SETTLE)) begin
            regRdData <= {6'h00, settleSel_r};
         end else if (hit(regAddr, ias_pkg::ADDR_LS_MODE)) begin
            regRdData <= {7'h00, lsStop_r};
         end else begin
            regRdData <= 8'h00;
         end
      end
   end

   // -----------------------------------------------------------------------
   // acknowledge decision
   // -----------------------------------------------------------------------
   // the one-cycle delay makes a flag set in the last clock miss this
   // instruction end and be taken at the following one
   always_ff @(posedge clk) begin
      if (srst) begin
         ackableDly_r <= 14'h0000;
      end else begin
         ackableDly_r <= ackable & ~(pickOneHot & {14{grant}});
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         holdOff_r <= 1'b0;
      end else if (flagAccess) begin
         holdOff_r <= 1'b1;
      end else if (instrEnd) begin
         holdOff_r <= 1'b0;
      end
   end

   ias_prio_pick u_pick (
      .req    (ackableDly_r & ackable),
      .valid  (pickValid),
      .idx    (pickIdx),
      .oneHot (pickOneHot)
   );

   // only at an instruction boundary, with enable set and no access hold
   assign grant = instrEnd && pickValid && ie_r && !holdOff_r && !flagAccess &&
                  (ackState_r == ias_pkg::ACK_IDLE) &&
                  (sbyState_r == ias_pkg::SBY_RUN);

   always_ff @(posedge clk) begin
      if (srst) begin
         ie_r <= ias_pkg::IE_RESET;
      end else if (grant) begin
         ie_r <= 1'b0;
      end else if (ieWrEn) begin
         ie_r <= ieWrVal;
      end
   end

   // -----------------------------------------------------------------------
   // entry sequence: status word, pc, vector load
   // -----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ackState_r <= ias_pkg::ACK_IDLE;
         grantIdx_r <= 4'h0;
      end else begin
         unique case (ackState_r)
            ias_pkg::ACK_IDLE: begin
               if (grant) begin
                  ackState_r <= ias_pkg::ACK_PSW;
                  grantIdx_r <= pickIdx;
               end
            end
            ias_pkg::ACK_PSW:  ackState_r <= ias_pkg::ACK_PC;
            ias_pkg::ACK_PC:   ackState_r <= ias_pkg::ACK_LOAD;
            ias_pkg::ACK_LOAD: ackState_r <= ias_pkg::ACK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         vectorAddr <= 16'h0000;
      end else if (grant) begin
         vectorAddr <= ias_pkg::VEC_BASE + 16'(pickIdx) * ias_pkg::VEC_STEP;
      end
   end

   assign ackStart   = grant;
   assign pushPswStb = (ackState_r == ias_pkg::ACK_PSW);
   assign pushPcStb  = (ackState_r == ias_pkg::ACK_PC);
   assign loadPcStb  = (ackState_r == ias_pkg::ACK_LOAD);
   assign ieFlag     = ie_r;

   // -----------------------------------------------------------------------
   // standby control
   // -----------------------------------------------------------------------
   // registers are never touched on entry or exit, so state survives
   assign settleStart = (sbyState_r == ias_pkg::SBY_OSCW) && oscRunning &&
                        sysClkResonator;

   always_ff @(posedge clk) begin
      if (srst) begin
         sbyState_r <= ias_pkg::SBY_RUN;
      end else begin
         unique case (sbyState_r)
            ias_pkg::SBY_RUN: begin
               if (stopReq) begin
                  sbyState_r <= ias_pkg::SBY_STOP;
               end else if (haltReq) begin
                  sbyState_r <= ias_pkg::SBY_HALT;
               end
            end
            ias_pkg::SBY_HALT: begin
               if (wake) begin
                  sbyState_r <= ias_pkg::SBY_RUN;
               end
            end
            ias_pkg::SBY_STOP: begin
               if (wake) begin
                  sbyState_r <= ias_pkg::SBY_OSCW;
               end
            end
            ias_pkg::SBY_OSCW: begin
               // time before the oscillator restarts is not counted
               if (oscRunning) begin
                  sbyState_r <= sysClkResonator ? ias_pkg::SBY_SETTLE
                                                : ias_pkg::SBY_LSTALL;
               end
            end
            ias_pkg::SBY_SETTLE: begin
               if (settleDone) begin
                  sbyState_r <= ias_pkg::SBY_LSTALL;
               end
            end
            ias_pkg::SBY_LSTALL: begin
               if (lowOscTick && lsTickCnt_r == ias_pkg::LS_STALL_TICKS - 4'h1) begin
                  sbyState_r <= ias_pkg::SBY_RUN;
               end
            end
            default: sbyState_r <= ias_pkg::SBY_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lsTickCnt_r <= 4'h0;
      end else if (sbyState_r != ias_pkg::SBY_LSTALL) begin
         lsTickCnt_r <= 4'h0;
      end else if (lowOscTick) begin
         lsTickCnt_r <= lsTickCnt_r + 4'h1;
      end
   end

   ias_settle_timer u_settle (
      .clk    (clk),
      .srst   (srst),
      .start  (settleStart),
      .length (settleLen(settleSel_r)),
      .busy   (settleBusy),
      .done   (settleDone)
   );

   // the stop bit is frozen out while the system oscillator is off
   always_ff @(posedge clk) begin
      if (srst) begin
         lowOscRun_r <= 1'b1;
      end else if (sbyState_r != ias_pkg::SBY_STOP) begin
         lowOscRun_r <= !(optLowOscStoppable && lsStop_r);
      end
   end

   assign cpuClkStop  = (sbyState_r != ias_pkg::SBY_RUN);
   assign sysOscStop  = (sbyState_r == ias_pkg::SBY_STOP);
   assign cpuStall    = (sbyState_r != ias_pkg::SBY_RUN) ||
                        (ackState_r != ias_pkg::ACK_IDLE);
   assign lowOscRun   = lowOscRun_r;
   assign standbyWake = wake;

   // -----------------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------------
   grant_unmasked_a: assert property (@(posedge clk) disable iff (srst)
      grant |-> ie_r && ackable[pickIdx])
      else $error("grant without enabled unmasked request");

   grant_priority_a: assert property (@(posedge clk) disable iff (srst)
      grant |-> ((ackableDly_r & ackable & (pickOneHot - 14'h0001)) == 14'h0000))
      else $error("lower priority source granted first");

   entry_order_a: assert property (@(posedge clk) disable iff (srst)
      grant |=> pushPswStb && !ie_r ##1 pushPcStb ##1 loadPcStb)
      else $error("entry push order wrong");

   flag_cleared_a: assert property (@(posedge clk) disable iff (srst)
      grant && !srcEvent[pickIdx] |=> !reqFlags_r[grantIdx_r])
      else $error("granted flag not cleared");

   access_hold_a: assert property (@(posedge clk) disable iff (srst)
      flagAccess |=> !grant)
      else $error("grant right after flag register access");

   halt_clock_a: assert property (@(posedge clk) disable iff (srst)
      $rose(sbyState_r == ias_pkg::SBY_HALT) |-> cpuClkStop && !sysOscStop)
      else $error("halt state clocks wrong");

   stop_wake_a: assert property (@(posedge clk) disable iff (srst)
      sbyState_r == ias_pkg::SBY_STOP && wake |=> sysOscStop == 1'b0 && cpuClkStop)
      else $error("stop release not stalled");

   halt_wake_a: assert property (@(posedge clk) disable iff (srst)
      sbyState_r == ias_pkg::SBY_HALT && wake |=> !cpuClkStop)
      else $error("halt not released by request");

   lowosc_hold_a: assert property (@(posedge clk) disable iff (srst)
      sbyState_r == ias_pkg::SBY_STOP && lowOscRun |=> lowOscRun)
      else $error("slow oscillator stopped in stop state");

   settle_start_a: assert property (@(posedge clk) disable iff (srst)
      settleStart |-> oscRunning ##1 settleBusy)
      else $error("settle count started without oscillator");

endmodule : ias_interrupt_ack_standby

// ### ias_pkg.sv
// constants, register map and state types for the interrupt acknowledge and
// standby block; assumes an 8-bit cpu register port and a 10 MHz cpu clock
package ias_pkg;

   // -----------------------------------------------------------------------
   // sources and vectors
   // -----------------------------------------------------------------------
   localparam int           NUM_SRC      = 14;
   localparam logic [15:0]  VEC_BASE     = 16'h0006;
   localparam logic [15:0]  VEC_STEP     = 16'h0002;

   // -----------------------------------------------------------------------
   // register addresses on the cpu data bus
   // -----------------------------------------------------------------------
   localparam logic [15:0]  ADDR_REQ_LO  = 16'hffe0;
   localparam logic [15:0]  ADDR_REQ_HI  = 16'hffe1;
   localparam logic [15:0]  ADDR_MASK_LO = 16'hffe4;
   localparam logic [15:0]  ADDR_MASK_HI = 16'hffe5;
   localparam logic [15:0]  ADDR_LS_MODE = 16'hff58;
   localparam logic [15:0]  ADDR_SETTLE  = 16'hfff4;

   // -----------------------------------------------------------------------
   // fields and reset values
   // -----------------------------------------------------------------------
   localparam int           LS_STOP_BIT  = 0;
   localparam int           SETTLE_LSB   = 0;
   localparam logic [13:0]  REQ_RESET    = 14'h0000;
   localparam logic [13:0]  MASK_RESET   = 14'h3fff;
   localparam logic [1:0]   SETTLE_RESET = 2'h3;
   localparam logic         LS_STOP_RST  = 1'b0;
   localparam logic         IE_RESET     = 1'b0;

   // -----------------------------------------------------------------------
   // timing counts, in clocks of the clock that paces them
   // -----------------------------------------------------------------------
   localparam int           SETTLE_CYC_0 = 1024;
   localparam int           SETTLE_CYC_1 = 4096;
   localparam int           SETTLE_CYC_2 = 32768;
   localparam int           SETTLE_CYC_3 = 131072;
   localparam logic [3:0]   LS_STALL_TICKS = 4'h8;

   // -----------------------------------------------------------------------
   // state types
   // -----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ACK_IDLE = 2'b00,
      ACK_PSW  = 2'b01,
      ACK_PC   = 2'b10,
      ACK_LOAD = 2'b11
   } ias_ack_state_t;

   typedef enum logic [2:0] {
      SBY_RUN    = 3'b000,
      SBY_HALT   = 3'b001,
      SBY_STOP   = 3'b010,
      SBY_OSCW   = 3'b011,
      SBY_SETTLE = 3'b100,
      SBY_LSTALL = 3'b101
   } ias_sby_state_t;

endpackage : ias_pkg

// ### ias_prio_pick.sv
// fixed-priority picker over the acknowledgeable sources
// assumes bit 0 is the highest priority source
`timescale 1ns/1ns
module ias_prio_pick (
   input  wire logic [13:0] req,
   output logic             valid,
   output logic [3:0]       idx,
   output logic [13:0]      oneHot
);

   always_comb begin
      valid  = 1'b0;
      idx    = 4'h0;
      oneHot = 14'h0000;
      for (int i = ias_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid  = 1'b1;
            idx    = 4'(i);
            oneHot = 14'h0001 << i;
         end
      end
   end

endmodule : ias_prio_pick

// ### ias_settle_timer.sv
// down-counter for the oscillator settle wait
// assumes start is a one-cycle pulse and length is at least one
`timescale 1ns/1ns
module ias_settle_timer (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic [17:0] length,
   output logic             busy,
   output logic             done
);

   logic [17:0] count_r;
   logic        busy_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         count_r <= 18'h00000;
         busy_r  <= 1'b0;
      end else if (start) begin
         count_r <= length - 18'h00001;
         busy_r  <= 1'b1;
      end else if (busy_r) begin
         if (count_r == 18'h00000) begin
            busy_r <= 1'b0;
         end else begin
            count_r <= count_r - 18'h00001;
         end
      end
   end

   assign busy = busy_r;
   assign done = busy_r && (count_r == 18'h00000);

endmodule : ias_settle_timer

// ### ias_cpu_model.sv
// cpu sequencer and oscillator stand-in facing the acknowledge block
// assumes the bench drives clk and srst; outputs move on the falling edge
`timescale 1ns/1ns
module ias_cpu_model (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic cpuStall,
   input  wire logic sysOscStop,
   output logic      instrEnd,
   output logic      oscRunning,
   output logic      lowOscTick
);
   logic [1:0] phase;
   logic [2:0] tickDiv;
   logic [1:0] oscDly;
   // ----------------------------------------------------------------
   // four-clock instructions, none issued while the core is stalled
   // ----------------------------------------------------------------
   always @(negedge clk) begin
      phase <= (srst || cpuStall) ? 2'h0 : phase + 2'h1;
      instrEnd <= !srst && !cpuStall && (phase == 2'h2);
      tickDiv <= (srst || tickDiv == 3'h4) ? 3'h0 : tickDiv + 3'h1;
      lowOscTick <= (tickDiv == 3'h4);
      // restart gap before oscillation, not part of the settle wait
      oscDly <= sysOscStop ? 2'h0 : ((oscDly == 2'h3) ? 2'h3 : oscDly + 2'h1);
      oscRunning <= !sysOscStop && (oscDly == 2'h3);
   end
endmodule : ias_cpu_model

// ### ias_interrupt_ack_standby_tb_top.sv
// self-checking bench for the interrupt acknowledge and standby block
// assumes a 10 MHz clock and short settle counts for simulation
`timescale 1ns/1ns
module ias_interrupt_ack_standby_tb_top;
   logic clk=0, srst=1, regWrEn=0, regRdEn=0, ieWrEn=0, ieWrVal=0, haltReq=0, stopReq=0;
   logic sysClkResonator=0, instrEnd, oscRunning, lowOscTick, ieFlag, ackStart;
   logic pushPswStb, pushPcStb, loadPcStb, cpuClkStop, sysOscStop, lowOscRun, cpuStall;
   logic standbyWake, hit, optStop=0;
   logic [13:0] srcEvent=0;
   logic [15:0] regAddr=0, vectorAddr;
   logic [7:0]  regWrData=0, regRdData, d;
   int          errCount=0, checks=0, n;
   initial forever #50 clk = ~clk;
   ias_interrupt_ack_standby #(.SETTLE_CYC_0(4), .SETTLE_CYC_1(8), .SETTLE_CYC_2(16),
      .SETTLE_CYC_3(32)) ias_interrupt_ack_standby_i (.clk(clk), .srst(srst),
      .srcEvent(srcEvent), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regWrData(regWrData), .regRdData(regRdData), .instrEnd(instrEnd), .ieWrEn(ieWrEn),
      .ieWrVal(ieWrVal), .ieFlag(ieFlag), .ackStart(ackStart), .pushPswStb(pushPswStb),
      .pushPcStb(pushPcStb), .loadPcStb(loadPcStb), .vectorAddr(vectorAddr),
      .haltReq(haltReq), .stopReq(stopReq), .sysClkResonator(sysClkResonator),
      .oscRunning(oscRunning), .lowOscTick(lowOscTick), .optLowOscStoppable(optStop),
      .cpuClkStop(cpuClkStop), .sysOscStop(sysOscStop), .lowOscRun(lowOscRun),
      .cpuStall(cpuStall), .standbyWake(standbyWake));
   ias_cpu_model ias_cpu_model_i (.clk(clk), .srst(srst), .cpuStall(cpuStall),
      .sysOscStop(sysOscStop), .instrEnd(instrEnd), .oscRunning(oscRunning),
      .lowOscTick(lowOscTick));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(negedge clk);
      regAddr = a;
      regWrData = v;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(negedge clk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge clk);
      regRdEn = 1'b0;
      v = regRdData;
   endtask : rd
   task automatic pulse_ev(input logic [13:0] b);
      @(negedge clk);
      srcEvent = b;
      @(negedge clk);
      srcEvent = 14'h0000;
   endtask : pulse_ev
   task automatic set_ie();
      @(negedge clk);
      ieWrEn = 1'b1;
      ieWrVal = 1'b1;
      @(negedge clk);
      ieWrEn = 1'b0;
   endtask : set_ie
   // a grant must show within forty clocks; stops at the grant cycle
   // the current cycle is looked at first so a grant right after the caller is not missed
   task automatic wait_ack(output logic h);
      h = 1'b0;
      for (int i = 0; i < 40 && !h; i++) begin
         #1 h = (ackStart === 1'b1);
         if (!h) @(negedge clk);
      end
   endtask : wait_ack
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      rd(ias_pkg::ADDR_MASK_LO, d); chk("mask lo", 16'h00ff, {8'h00, d});
      rd(ias_pkg::ADDR_REQ_LO, d); chk("req lo", 16'h0000, {8'h00, d});
      rd(ias_pkg::ADDR_SETTLE, d); chk("settle", 16'h0003, {8'h00, d});
      rd(16'hff00, d); chk("unmapped", 16'h0000, {8'h00, d});
      $display("reset test done");
   endtask : t_reset
   task automatic t_prio();
      wr(ias_pkg::ADDR_MASK_LO, 8'h00);
      wr(ias_pkg::ADDR_MASK_HI, 8'h00);
      pulse_ev(14'h0012);
      chk("wake", 16'h0001, {15'h0000, standbyWake});
      wait_ack(hit); chk("ack ie off", 16'h0000, {15'h0000, hit});
      set_ie();
      wait_ack(hit); chk("ack", 16'h0001, {15'h0000, hit});
      @(negedge clk);
      chk("vector", 16'h0008, vectorAddr);
      chk("psw push", 16'h0001, {15'h0000, pushPswStb});
      chk("ie cleared", 16'h0000, {15'h0000, ieFlag});
      chk("entry stall", 16'h0001, {15'h0000, cpuStall});
      @(negedge clk);
      chk("pc push", 16'h0001, {15'h0000, pushPcStb});
      @(negedge clk);
      chk("pc load", 16'h0001, {15'h0000, loadPcStb});
      wait_ack(hit); chk("no nest", 16'h0000, {15'h0000, hit});
      set_ie();
      wait_ack(hit); chk("ack 2", 16'h0001, {15'h0000, hit});
      @(negedge clk);
      chk("vector 2", 16'h000e, vectorAddr);
      rd(ias_pkg::ADDR_REQ_LO, d); chk("flags clear", 16'h0000, {8'h00, d});
      $display("priority test done");
   endtask : t_prio
   task automatic t_halt();
      @(negedge clk); haltReq = 1'b1;
      @(negedge clk); haltReq = 1'b0;
      chk("halt clk", 16'h0001, {15'h0000, cpuClkStop});
      chk("halt osc", 16'h0000, {15'h0000, sysOscStop});
      pulse_ev(14'h2000);
      repeat (3) @(negedge clk);
      chk("halt exit", 16'h0000, {15'h0000, cpuClkStop});
      wait_ack(hit); chk("halt no entry", 16'h0000, {15'h0000, hit});
      rd(ias_pkg::ADDR_REQ_HI, d); chk("kept flag", 16'h0020, {8'h00, d});
      wr(ias_pkg::ADDR_REQ_HI, 8'h00);
      $display("halt test done");
   endtask : t_halt
   task automatic t_lowosc();
      wr(ias_pkg::ADDR_LS_MODE, 8'h01);
      @(negedge clk);
      chk("slow fixed", 16'h0001, {15'h0000, lowOscRun});
      rd(ias_pkg::ADDR_LS_MODE, d); chk("slow mode", 16'h0001, {8'h00, d});
      optStop = 1'b1;
      repeat (2) @(negedge clk);
      chk("slow stopped", 16'h0000, {15'h0000, lowOscRun});
      wr(ias_pkg::ADDR_LS_MODE, 8'h00);
      @(negedge clk);
      chk("slow restart", 16'h0001, {15'h0000, lowOscRun});
      $display("slow oscillator test done");
   endtask : t_lowosc
   task automatic t_stop(input logic res, input logic [7:0] code, input int lo, input int hi);
      wr(ias_pkg::ADDR_SETTLE, code);
      sysClkResonator = res;
      @(negedge clk); stopReq = 1'b1;
      @(negedge clk); stopReq = 1'b0;
      chk("stop osc", 16'h0001, {15'h0000, sysOscStop});
      chk("slow osc", 16'h0001, {15'h0000, lowOscRun});
      pulse_ev(14'h0001);
      n = 0;
      while (cpuClkStop === 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      // 4 clocks to restart, the settle length, then 8 slow ticks 5 clocks apart
      chk("stop wait", 16'h0001, {15'h0000, n >= lo && n <= hi});
      set_ie();
      wait_ack(hit);
      @(negedge clk);
      chk("stop vector", 16'h0006, vectorAddr);
      $display("stop test done");
   endtask : t_stop
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   initial begin
      #300000;
      errCount++;
      complete_run();
   end
   initial begin
      repeat (3) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_prio();
      t_halt();
      t_lowosc();
      // upper settle bits are ignored, so 0xfc selects the shortest wait
      t_stop(1'b1, 8'hfc, 44, 50);
      t_stop(1'b1, 8'h03, 72, 78);
      t_stop(1'b0, 8'h03, 40, 46);
      complete_run();
   end
endmodule : ias_interrupt_ack_standby_tb_top
